// file: valve_output_param_diag.sv
// Valve driver node: parameter byte, output freeze/clear, coil diagnosis reports
`default_nettype none
`include "valve_node_regs.svh"

module valve_output_param_diag #(
  parameter int NOUT        = `NUM_OUTPUTS,
  parameter int TIMEOUT_CYC = `LINK_TIMEOUT_CYC,
  parameter int CENSUS_CYC  = 16
) (
  input  wire logic                           CLOCK,
  input  wire logic                           RST_N,
  input  wire logic                           PARAM_WE,
  input  wire logic [7:0]                     PARAM_WDATA,
  output logic      [7:0]                     PARAM_SHADOW,
  output logic      [7:0]                     PARAM_ACTIVE,
  input  wire logic                           FRAME_VALID,
  input  wire logic [8*`MAX_OUT_BYTES-1:0]    FRAME_DATA,
  input  wire logic [1:0]                     LEN_SEL,
  input  wire logic [NOUT-1:0]                COIL_PRESENT,
  input  wire logic [NOUT-1:0]                COIL_SHORT,
  input  wire logic                           ELEC_SUPPLY_FAULT,
  input  wire logic                           VALVE_SUPPLY_FAULT,
  output logic      [NOUT-1:0]                COIL_DRIVE,
  output logic                                LINK_FAILED,
  output logic      [8*(`MAX_OUT_BYTES+1)-1:0] DIAG_DATA,
  output logic                                DIAG_EVENT
);
  localparam int DW = 8 * `MAX_OUT_BYTES;
  localparam int CCW = $clog2(CENSUS_CYC + 1);

  valve_node_pkg::param_byte_t shadow_q, active_q;
  valve_node_pkg::diag_state_t state_q, state_d;
  logic [NOUT-1:0]  out_q, out_d;
  logic [NOUT-1:0]  census_q, fault_q, fault_d;
  logic [DW-1:0]    diag_out_q, diag_prev_q;
  logic [7:0]       diag_hdr_q;
  logic             event_q, event_d;
  logic [CCW-1:0]   ccnt_q;
  logic             rst_seen_q;
  wire              link_failed;

  link_watchdog #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_wd (
    .CLOCK       (CLOCK),
    .RST_N       (RST_N),
    .frame_ok    (FRAME_VALID),
    .link_failed (link_failed)
  );

  // Only bits 1 and 3 have meaning; reserved bits are held as written in the shadow but read as zero on PARAM_ACTIVE
  wire freeze_mode = active_q[`PARAM_BIT_FREEZE];
  wire change_mode = active_q[`PARAM_BIT_DIAG];

  // Mask of outputs covered by the configured byte length
  function automatic logic [DW-1:0] len_mask(input logic [1:0] sel);
    logic [DW-1:0] m;
    m = '0;
    for (int i = 0; i < DW; i++) begin
      if (i < 8 * (int'(sel) + 1)) m[i] = 1'b1;
    end
    return m;
  endfunction

  wire [DW-1:0]   lmask  = len_mask(LEN_SEL);
  wire [NOUT-1:0] frame_outs = FRAME_DATA[NOUT-1:0] & lmask[NOUT-1:0];

  // Shadow takes every write; active copies shadow only while reset is held and on the first clock after release
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rst_seen_q <= 1'b1;
    end else begin
      rst_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (PARAM_WE) shadow_q <= PARAM_WDATA;
  end

  // Shadow survives the device reset; active loads from it only at restart
  always_ff @(posedge CLOCK) begin
    if (rst_seen_q) begin
      active_q <= shadow_q;
    end
  end

  // Output data path
  always_comb begin
    out_d = out_q;
    if (FRAME_VALID) begin
      out_d = frame_outs;
    end else if (link_failed && !freeze_mode) begin
      out_d = '0;
    end
    // Freeze mode keeps out_q while the link is down
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) out_q <= '0;
    else        out_q <= out_d;
  end

  // Fault per output: short or missing coil while driven; missing coil while undriven in change mode only
  genvar g;
  generate
    for (g = 0; g < NOUT; g++) begin : g_fault
      always_comb begin
        if (out_q[g]) begin
          fault_d[g] = COIL_SHORT[g] | ~COIL_PRESENT[g];
        end else if (change_mode) begin
          fault_d[g] = ~COIL_PRESENT[g];
        end else begin
          fault_d[g] = 1'b0;
        end
      end
    end
  endgenerate

  wire [DW-1:0] fault_ext = DW'(fault_q) & lmask;
  wire [7:0]    hdr_d     = {link_failed, 5'h00, VALVE_SUPPLY_FAULT, ELEC_SUPPLY_FAULT};
  wire          diag_diff = (fault_ext != diag_prev_q);

  // Diagnosis state machine
  always_comb begin
    state_d = state_q;
    event_d = 1'b0;
    unique case (state_q)
      valve_node_pkg::ST_CENSUS: begin
        if (!change_mode) state_d = valve_node_pkg::ST_RUN;
        else if (ccnt_q == CCW'(CENSUS_CYC - 1)) state_d = valve_node_pkg::ST_SEND_CENSUS;
      end
      valve_node_pkg::ST_SEND_CENSUS: begin
        event_d = 1'b1;
        state_d = valve_node_pkg::ST_RUN;
      end
      valve_node_pkg::ST_RUN: begin
        event_d = change_mode ? diag_diff : 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_q  <= valve_node_pkg::ST_CENSUS;
      ccnt_q   <= '0;
      census_q <= '0;
      fault_q  <= '0;
      event_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      fault_q <= fault_d;
      event_q <= event_d;
      if (state_q == valve_node_pkg::ST_CENSUS) begin
        ccnt_q   <= ccnt_q + 1'b1;
        census_q <= COIL_PRESENT;
      end
    end
  end

  // Report registers: in change mode census image first, then whole range on each change; otherwise fault image every cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      diag_out_q  <= '0;
      diag_prev_q <= '0;
      diag_hdr_q  <= 8'h00;
    end else begin
      diag_hdr_q <= hdr_d;
      if (state_q == valve_node_pkg::ST_SEND_CENSUS) begin
        diag_out_q  <= DW'(~census_q) & lmask;
        diag_prev_q <= DW'(~census_q) & lmask;
      end else if (!change_mode) begin
        diag_out_q  <= fault_ext;
      end else if (state_q == valve_node_pkg::ST_RUN && diag_diff) begin
        diag_out_q  <= fault_ext;
        diag_prev_q <= fault_ext;
      end
    end
  end

  assign PARAM_SHADOW = shadow_q;
  assign PARAM_ACTIVE = active_q & `PARAM_USED_MASK;
  assign COIL_DRIVE   = out_q;
  assign LINK_FAILED  = link_failed;
  assign DIAG_DATA    = {diag_out_q, diag_hdr_q};
  assign DIAG_EVENT   = event_q;

  a_clear_on_fail: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (link_failed && !freeze_mode && !FRAME_VALID) |=> (COIL_DRIVE == '0))
    else $error("outputs not cleared on link failure");
  a_freeze_on_fail: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (link_failed && freeze_mode && !FRAME_VALID) |=> $stable(COIL_DRIVE))
    else $error("outputs not frozen on link failure");
  a_frame_loads: assert property (@(posedge CLOCK) disable iff (!RST_N)
    FRAME_VALID |=> (COIL_DRIVE == $past(frame_outs)))
    else $error("frame data not applied");
  a_active_stable: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (RST_N && $past(RST_N) && $past(RST_N, 2)) |-> $stable(active_q))
    else $error("active parameter changed in operation");
  a_shadow_write: assert property (@(posedge CLOCK) disable iff (!RST_N)
    PARAM_WE |=> (PARAM_SHADOW == $past(PARAM_WDATA)))
    else $error("shadow not written");
  a_no_event_plain: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !change_mode |-> !event_d) else $error("event raised in driven-only mode");
  a_undriven_short: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (!out_q[0] && COIL_PRESENT[0]) |=> !fault_q[0])
    else $error("short flagged on undriven output");
  a_missing_coil: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (out_q[0] && !COIL_PRESENT[0]) |=> fault_q[0])
    else $error("missing coil on driven output not flagged");
  a_census_report: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (state_q == valve_node_pkg::ST_SEND_CENSUS) |=> DIAG_EVENT)
    else $error("census report not sent");
  a_change_event: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (change_mode && state_q == valve_node_pkg::ST_RUN && diag_diff) |=> DIAG_EVENT ##0 (diag_out_q == $past(fault_ext)))
    else $error("change report missing");
  a_open_undriven: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (change_mode && !out_q[0] && !COIL_PRESENT[0]) |=> fault_q[0])
    else $error("open load not flagged");
  a_hdr_link: assert property (@(posedge CLOCK) disable iff (!RST_N)
    link_failed |=> DIAG_DATA[`DIAG0_BIT_LINK]) else $error("link flag missing");
endmodule // valve_output_param_diag
`default_nettype wire

// file: valve_node_regs.svh
// Constants for the valve output parameter and diagnosis node
`ifndef VALVE_NODE_REGS_SVH
`define VALVE_NODE_REGS_SVH

`define PARAM_RESET        8'h00
`define PARAM_BIT_DIAG     1
`define PARAM_BIT_FREEZE   3
`define PARAM_USED_MASK    8'h0a
`define DIAG0_BIT_ELEC     0
`define DIAG0_BIT_VALVE    1
`define DIAG0_BIT_LINK     7
`define NUM_OUTPUTS        24
`define MAX_OUT_BYTES      4
`define LINK_TIMEOUT_US    20
`define LINK_TIMEOUT_CYC   ((`LINK_TIMEOUT_US * 25 + 0) )

`endif

// file: valve_node_pkg.sv
// Types for the valve output parameter and diagnosis node
`default_nettype none
package valve_node_pkg;
  typedef enum logic [1:0] {ST_CENSUS, ST_SEND_CENSUS, ST_RUN} diag_state_t;
  typedef logic [7:0] param_byte_t;
endpackage
`default_nettype wire

// file: link_watchdog.sv
// Link failure detector: times out between valid frames
`default_nettype none
module link_watchdog #(
  parameter int TIMEOUT_CYC = 500
) (
  input  wire logic CLOCK,
  input  wire logic RST_N,
  input  wire logic frame_ok,
  output logic      link_failed
);
  localparam int CW = $clog2(TIMEOUT_CYC + 1);
  logic [CW-1:0] cnt_q;
  logic          failed_q;
  wire           expired = (cnt_q == CW'(TIMEOUT_CYC - 1));

  // Failure declared when no valid frame within the timeout; next frame clears it
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      cnt_q    <= '0;
      failed_q <= 1'b0;
    end else if (frame_ok) begin
      cnt_q    <= '0;
      failed_q <= 1'b0;
    end else if (expired) begin
      failed_q <= 1'b1;
    end else begin
      cnt_q    <= cnt_q + 1'b1;
    end
  end
  assign link_failed = failed_q;

  a_fail_after_timeout: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (!frame_ok && expired) |=> link_failed) else $error("link not failed at timeout");
  a_frame_clears_fail: assert property (@(posedge CLOCK) disable iff (!RST_N)
    frame_ok |=> !link_failed) else $error("frame did not clear failure");
endmodule // link_watchdog
`default_nettype wire

// file: coupler_model.sv
// Bus coupler model: cyclic frames, acyclic parameter bytes, report capture
`default_nettype none
module coupler_model (
  input  wire logic        CLOCK,
  input  wire logic        DIAG_EVENT,
  input  wire logic [39:0] DIAG_DATA,
  output logic             FRAME_VALID,
  output logic      [31:0] FRAME_DATA,
  output logic             PARAM_WE,
  output logic      [7:0]  PARAM_WDATA,
  output logic      [39:0] REPORT
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    FRAME_VALID = 1'b0;
    FRAME_DATA  = 32'h0;
    PARAM_WE    = 1'b0;
    PARAM_WDATA = 8'h0;
    REPORT      = 40'h0;
  end
  // Change reports are passed upward as event messages
  always @(posedge CLOCK) if (DIAG_EVENT) REPORT <= DIAG_DATA;
  // Data shows its inverse once the frame is over
  task automatic send(input logic [31:0] d);
    @(posedge CLOCK);
    FRAME_VALID <= 1'b1;
    FRAME_DATA  <= d;
    @(posedge CLOCK);
    FRAME_VALID <= 1'b0;
    FRAME_DATA  <= ~d;
  endtask
  // Parameter byte travels outside the cyclic exchange
  task automatic put_param(input logic [7:0] p);
    @(posedge CLOCK);
    PARAM_WE    <= 1'b1;
    PARAM_WDATA <= p;
    @(posedge CLOCK);
    PARAM_WE    <= 1'b0;
    PARAM_WDATA <= ~p;
  endtask
endmodule // coupler_model
`default_nettype wire

// file: test_valve_output_param_diag.sv
// Self-checking bench for the valve output parameter and diagnosis node
`default_nettype none
module test_valve_output_param_diag;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLOCK = 1'b0;
  logic        RST_N = 1'b0;
  logic        ELEC_SUPPLY_FAULT;
  logic        VALVE_SUPPLY_FAULT;
  logic [1:0]  LEN_SEL;
  logic [23:0] COIL_PRESENT;
  logic [23:0] COIL_SHORT;
  logic        FRAME_VALID, PARAM_WE, LINK_FAILED, DIAG_EVENT;
  logic [7:0]  PARAM_WDATA, PARAM_SHADOW, PARAM_ACTIVE;
  logic [23:0] COIL_DRIVE;
  logic [31:0] FRAME_DATA;
  logic [39:0] DIAG_DATA, REPORT;
  int          n_fail = 0;
  int          n_tests = 0;
  always #20 CLOCK = ~CLOCK;
  valve_output_param_diag #(.TIMEOUT_CYC(8), .CENSUS_CYC(4)) valve_output_param_diag_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .PARAM_WE(PARAM_WE), .PARAM_WDATA(PARAM_WDATA),
    .PARAM_SHADOW(PARAM_SHADOW), .PARAM_ACTIVE(PARAM_ACTIVE), .FRAME_VALID(FRAME_VALID),
    .FRAME_DATA(FRAME_DATA), .LEN_SEL(LEN_SEL), .COIL_PRESENT(COIL_PRESENT), .COIL_SHORT(COIL_SHORT),
    .ELEC_SUPPLY_FAULT(ELEC_SUPPLY_FAULT), .VALVE_SUPPLY_FAULT(VALVE_SUPPLY_FAULT),
    .COIL_DRIVE(COIL_DRIVE), .LINK_FAILED(LINK_FAILED), .DIAG_DATA(DIAG_DATA), .DIAG_EVENT(DIAG_EVENT));
  coupler_model coupler_model_inst (.CLOCK(CLOCK), .DIAG_EVENT(DIAG_EVENT), .DIAG_DATA(DIAG_DATA),
    .FRAME_VALID(FRAME_VALID), .FRAME_DATA(FRAME_DATA), .PARAM_WE(PARAM_WE),
    .PARAM_WDATA(PARAM_WDATA), .REPORT(REPORT));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({39'h0, got}, {39'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic restart();
    @(posedge CLOCK) RST_N <= 1'b0;
    tick(2);
    @(posedge CLOCK) RST_N <= 1'b1;
    tick(2);
  endtask
  task automatic wait_fail();
    for (int i = 0; i < 30 && LINK_FAILED !== 1'b1; i++) tick(1);
  endtask
  task automatic wait_event();
    for (int i = 0; i < 30 && DIAG_EVENT !== 1'b1; i++) tick(1);
  endtask
  task automatic s_length();
    logic [23:0] m [4] = '{24'hff, 24'hffff, 24'hffffff, 24'hffffff};
    for (int k = 0; k < 4; k++) begin
      @(posedge CLOCK) LEN_SEL <= k[1:0];
      restart();
      coupler_model_inst.send(32'h5aa5c33c);
      #1;
      chk(40'(COIL_DRIVE), 40'(24'ha5c33c & m[k]));
    end
  endtask
  task automatic s_clear_on_fail();
    coupler_model_inst.send(32'h00ff00ff);
    tick(4);
    chk1(LINK_FAILED, 1'b0);
    wait_fail();
    chk1(LINK_FAILED, 1'b1);
    tick(1);
    chk(40'(COIL_DRIVE), 40'h0);
    chk1(DIAG_DATA[7], 1'b1);
    coupler_model_inst.send(32'h1);
    tick(1);
    chk1(LINK_FAILED, 1'b0);
  endtask
  task automatic s_driven_diag();
    @(posedge CLOCK) begin
      COIL_PRESENT <= 24'hfffffc;
      COIL_SHORT <= 24'h000300;
      ELEC_SUPPLY_FAULT <= 1'b1;
      VALVE_SUPPLY_FAULT <= 1'b1;
    end
    coupler_model_inst.send(32'h00000101);
    tick(2);
    chk(40'(DIAG_DATA[31:0]), 40'h0000010103);
    chk1(DIAG_EVENT, 1'b0);
    @(posedge CLOCK) begin
      ELEC_SUPPLY_FAULT <= 1'b0;
      VALVE_SUPPLY_FAULT <= 1'b0;
      COIL_SHORT <= 24'h0;
      COIL_PRESENT <= 24'hff00ff;
    end
  endtask
  task automatic s_param_apply();
    coupler_model_inst.put_param(8'hff);
    tick(1);
    chk(40'(PARAM_SHADOW), 40'hff);
    chk(40'(PARAM_ACTIVE), 40'h00);
    restart();
    chk(40'(PARAM_ACTIVE), 40'h0a);
    wait_event();
    chk(40'(DIAG_DATA[31:8]), 40'h00ff00);
    tick(1);
    chk(40'(REPORT[31:8]), 40'h00ff00);
  endtask
  task automatic s_freeze_change();
    coupler_model_inst.send(32'h00a50000);
    tick(1);
    wait_fail();
    chk(40'(COIL_DRIVE), 40'ha50000);
    tick(20);
    @(posedge CLOCK) COIL_PRESENT <= 24'hff00fe;
    wait_event();
    chk(40'(DIAG_DATA[31:8]), 40'h00ff01);
    repeat (12) begin
      tick(1);
      chk1(DIAG_EVENT, 1'b0);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    ELEC_SUPPLY_FAULT <= 1'b0;
    VALVE_SUPPLY_FAULT <= 1'b0;
    LEN_SEL <= 2'h3;
    COIL_PRESENT <= 24'hffffff;
    COIL_SHORT <= 24'h0;
    // Shadow must be known before the first release loads the active byte
    coupler_model_inst.put_param(8'h00);
    @(posedge CLOCK) RST_N <= 1'b1;
    tick(1);
    chk(40'(COIL_DRIVE), 40'h0);
    coupler_model_inst.put_param(8'h00);
    restart();
    chk(40'(PARAM_ACTIVE), 40'h00);
    s_length();
    s_clear_on_fail();
    s_driven_diag();
    s_param_apply();
    s_freeze_change();
    summarize();
  end
  // Whole run needs a few hundred cycles at most
  initial begin
    #200000;
    n_fail++;
    summarize();
  end
endmodule // test_valve_output_param_diag
`default_nettype wire
